/* File: hw/sfac_defines.svh */
// Constants of the security fuse access control block.
// Assumes inclusion by bare name from the package and modules.
`ifndef SFAC_DEFINES_SVH
`define SFAC_DEFINES_SVH

`define SFAC_OPT_FUSE        8'h01
`define SFAC_FUSE_ADDR       8'hff
`define SFAC_FUSE_LEN        8'h00
`define SFAC_FUSE_DATA       8'h00
`define SFAC_PROG_ADDR_1ST   8'h06
`define SFAC_PROG_ADDR_2ND   8'h04
`define SFAC_PROG_ADDR_3RD   8'h00
`define SFAC_FUSE_RESET      4'h7
`define SFAC_FUSE_RSVD       4'h0
`define SFAC_BIT_LOCK_A      0
`define SFAC_BIT_LOCK_B      1
`define SFAC_BIT_LOCK_C      2
`define SFAC_BIT_FACTORY     3
`define SFAC_MTZ_LO          8'h0a
`define SFAC_MTZ_HI          8'h0b
`define SFAC_CMC_LO          8'h0c
`define SFAC_CMC_HI          8'h0d
`define SFAC_HWR_LO          8'h0e
`define SFAC_HWR_HI          8'h0f
`define SFAC_ANTI_HI         8'h0f
`define SFAC_LOT_HI          8'h17
`define SFAC_DCR_ADDR        8'h18
`define SFAC_AC_HI           8'h4f
`define SFAC_CRYPTO_HI       8'h8f
`define SFAC_KEY_COL         3'h4
`define SFAC_SECRET_HI       8'haf
`define SFAC_PW_HI           8'hef
`define SFAC_PAC_COL_MASK    3'h3
`define SFAC_BUSY_CYCLES     4'h2

`endif

/* File: hw/sfac_pkg.sv */
// Types of the security fuse access control block.
// Assumes the defines header is on the include path.
`include "sfac_defines.svh"

package sfac_pkg;
    typedef enum logic [1:0] {SFAC_CMD_NONE, SFAC_CMD_READ, SFAC_CMD_WRITE} sfac_cmd_t;
    typedef enum logic [3:0] {
        SFAC_AREA_ANTI, SFAC_AREA_MTZ, SFAC_AREA_CMC, SFAC_AREA_HWR, SFAC_AREA_LOT,
        SFAC_AREA_DCR, SFAC_AREA_AC, SFAC_AREA_CRYPTO, SFAC_AREA_KEY, SFAC_AREA_SECRET,
        SFAC_AREA_PW, SFAC_AREA_PAC, SFAC_AREA_FORBID
    } sfac_area_t;
endpackage

/* File: hw/sfac_dec_if.sv */
// Carries an address and its decoded area between the top and the decoder.
// Assumes the package is compiled first.
`timescale 1ns/10ps

interface sfac_dec_if;
    import sfac_pkg::*;
    logic [7:0] addr;
    sfac_area_t area;
    logic [2:0] pw_set;
    modport dec (input addr, output area, output pw_set);
    modport top (output addr, input area, input pw_set);
endinterface

/* File: hw/sfac_area_dec.sv */
// Maps a configuration memory address to its access area.
// Assumes an 8-bit configuration address space.
`timescale 1ns/10ps
`include "sfac_defines.svh"

module sfac_area_dec
    import sfac_pkg::*;
(
    sfac_dec_if.dec d
);
    always_comb
    begin
        d.pw_set = d.addr[5:3] - 3'h6;
        if (d.addr >= `SFAC_MTZ_LO && d.addr <= `SFAC_MTZ_HI)
            d.area = SFAC_AREA_MTZ;
        else if (d.addr >= `SFAC_CMC_LO && d.addr <= `SFAC_CMC_HI)
            d.area = SFAC_AREA_CMC;
        else if (d.addr >= `SFAC_HWR_LO && d.addr <= `SFAC_HWR_HI)
            d.area = SFAC_AREA_HWR;
        else if (d.addr <= `SFAC_ANTI_HI)
            d.area = SFAC_AREA_ANTI;
        else if (d.addr <= `SFAC_LOT_HI)
            d.area = SFAC_AREA_LOT;
        else if (d.addr == `SFAC_DCR_ADDR)
            d.area = SFAC_AREA_DCR;
        else if (d.addr <= `SFAC_AC_HI)
            d.area = SFAC_AREA_AC;
        else if (d.addr <= `SFAC_CRYPTO_HI)
            d.area = (d.addr[3] && d.addr[2:0] >= `SFAC_KEY_COL) ? SFAC_AREA_KEY : SFAC_AREA_CRYPTO;
        else if (d.addr <= `SFAC_SECRET_HI)
            d.area = SFAC_AREA_SECRET;
        else if (d.addr <= `SFAC_PW_HI)
            d.area = ((d.addr[2:0] & `SFAC_PAC_COL_MASK) == 3'h0) ? SFAC_AREA_PAC : SFAC_AREA_PW;
        else
            d.area = SFAC_AREA_FORBID;
    end
endmodule

/* File: hw/sfac_fuse_cell.sv */
// One one-time-programmable fuse cell; only a program pulse or reset (which reloads INIT) changes it.
// Assumes the factory value is given as a parameter.
`timescale 1ns/10ps

module sfac_fuse_cell #(
    parameter logic INIT = 1'b1
) (
    input  wire logic CLK,
    input  wire logic RESET_N,
    input  wire logic program_pulse,
    output logic      blown
);
    logic state_ff;
    logic nxt_state;

    always_comb
    begin
        nxt_state = state_ff & ~program_pulse;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state_ff <= INIT;
        else
            state_ff <= nxt_state;
    end

    assign blown = ~state_ff;
endmodule

/* File: hw/sfac_top.sv */
// Security fuse byte, fuse programming order and configuration access gating.
// Assumes the command decoder presents one-cycle command strobes.
// Operation
// - Programmed fuses never return to unprogrammed, except by reset.
// - Fuses gate configuration memory only, not user zones.
// - Read with option 01h, address FFh, length 00h returns the fuse byte.
// - Fuse bit zero means programmed, one means unprogrammed.
// - Bits four to seven reserved, ignored by access decisions.
// - First line: bit0 first lock, bit1 maker lock, bit2 issue, bit3 factory.
// - Second line: bit0 issue, bit1 secret lock, bit2 cipher, bit3 factory.
// - Program via write 01h, addresses 06h, 04h, 00h in order; reject others.
// - Each fuse program answers acknowledge plus fuse byte in status.
// - All three fuses programmed locks configuration to most restrictive column.
// - Factory default: factory fuse zero, others one.
// - First line: general reads always open; lot history writes refused.
// - First line: anticollision write needs transport password until first lock.
// - First line: keys, secrets, control writes need transport password until issue lock.
// - Second line uses own matrix with secret lock and cipher fuses.
// - Transport password access only after a validated password check.
// - Set write password grants only its own set's counter and passwords.
`timescale 1ns/10ps
`include "sfac_defines.svh"

module sfac_top
    import sfac_pkg::*;
#(
    parameter bit PRODUCT_LINE_B = 1'b0
) (
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic       CMD_READ,
    input  wire logic       CMD_WRITE,
    input  wire logic [7:0] CMD_OPTION,
    input  wire logic [7:0] CMD_ADDR,
    input  wire logic [7:0] CMD_LEN,
    input  wire logic [7:0] CMD_DATA,
    input  wire logic       TRANSPORT_PASSWORD_OK,
    input  wire logic       SET_SET_WRITE_PASSWORD_OK,
    input  wire logic [2:0] SET_SET_WRITE_PASSWORD_SET,
    input  wire logic       SESSION_END,
    input  wire logic       ENCRYPTION_ACTIVE,
    output logic            RESP_VALID,
    output logic            RESP_ACK,
    output logic            RESP_GRANT,
    output logic            RESP_HAS_DATA,
    output logic [7:0]      RESP_DATA,
    output logic [7:0]      STATUS_FUSE,
    output logic            CONFIG_LOCKED
);
    logic [3:0] fuse_ok;
    logic [2:0] prog_pulse;
    sfac_dec_if dif();

    sfac_fuse_cell #(.INIT(1'b1)) u_fuse0 (.CLK(CLK), .RESET_N(RESET_N), .program_pulse(prog_pulse[0]),
                                           .blown(fuse_ok[0]));
    sfac_fuse_cell #(.INIT(1'b1)) u_fuse1 (.CLK(CLK), .RESET_N(RESET_N), .program_pulse(prog_pulse[1]),
                                           .blown(fuse_ok[1]));
    sfac_fuse_cell #(.INIT(1'b1)) u_fuse2 (.CLK(CLK), .RESET_N(RESET_N), .program_pulse(prog_pulse[2]),
                                           .blown(fuse_ok[2]));
    sfac_fuse_cell #(.INIT(1'b0)) u_fuse3 (.CLK(CLK), .RESET_N(RESET_N), .program_pulse(1'b0),
                                           .blown(fuse_ok[3]));

    assign dif.addr = CMD_ADDR;
    sfac_area_dec u_dec (.d(dif.dec));

    // Fuse byte: low nibble is fuse state (1 = unprogrammed)
    logic [7:0] fuse_byte;
    assign fuse_byte = {`SFAC_FUSE_RSVD, ~fuse_ok};

    // Named fuse views; physical programming slots are order 06h,04h,00h
    logic lock_a_blown;
    logic lock_b_blown;
    logic issue_blown;
    // second line naming, first line naming
    always_comb
    begin
        if (PRODUCT_LINE_B)
        begin
            issue_blown  = fuse_ok[`SFAC_BIT_LOCK_A];
            lock_b_blown = fuse_ok[`SFAC_BIT_LOCK_B];
            lock_a_blown = fuse_ok[`SFAC_BIT_LOCK_C];
        end
        else
        begin
            lock_a_blown = fuse_ok[`SFAC_BIT_LOCK_A];
            lock_b_blown = fuse_ok[`SFAC_BIT_LOCK_B];
            issue_blown  = fuse_ok[`SFAC_BIT_LOCK_C];
        end
    end

    // Session password state
    logic       tpw_ff;
    logic       nxt_tpw;
    logic       wpw_ff;
    logic       nxt_wpw;
    logic [2:0] wset_ff;
    logic [2:0] nxt_wset;

    // transport password held for the session
    always_comb
    begin
        nxt_tpw  = tpw_ff;
        nxt_wpw  = wpw_ff;
        nxt_wset = wset_ff;
        if (SESSION_END)
        begin
            nxt_tpw = 1'b0;
            nxt_wpw = 1'b0;
        end
        if (TRANSPORT_PASSWORD_OK)
            nxt_tpw = 1'b1;
        if (SET_SET_WRITE_PASSWORD_OK)
        begin
            nxt_wpw  = 1'b1;
            nxt_wset = SET_SET_WRITE_PASSWORD_SET;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            tpw_ff  <= 1'b0;
            wpw_ff  <= 1'b0;
            wset_ff <= 3'h0;
        end
        else
        begin
            tpw_ff  <= nxt_tpw;
            wpw_ff  <= nxt_wpw;
            wset_ff <= nxt_wset;
        end
    end

    // Command classification
    logic is_fuse_read;
    logic is_fuse_prog;
    logic order_ok;
    assign is_fuse_read = CMD_READ && CMD_OPTION == `SFAC_OPT_FUSE && CMD_ADDR == `SFAC_FUSE_ADDR
                          && CMD_LEN == `SFAC_FUSE_LEN;
    assign is_fuse_prog = CMD_WRITE && CMD_OPTION == `SFAC_OPT_FUSE && CMD_LEN == `SFAC_FUSE_LEN
                          && CMD_DATA == `SFAC_FUSE_DATA;

    // strict order: each slot only after the previous one
    always_comb
    begin
        prog_pulse = 3'h0;
        order_ok   = 1'b0;
        if (is_fuse_prog)
        begin
            case (CMD_ADDR)
                `SFAC_PROG_ADDR_1ST: order_ok = !prog_slot(0);
                `SFAC_PROG_ADDR_2ND: order_ok = prog_slot(0) && !prog_slot(1);
                `SFAC_PROG_ADDR_3RD: order_ok = prog_slot(1) && !prog_slot(2);
                default:             order_ok = 1'b0;
            endcase
            if (order_ok)
                prog_pulse = slot_mask(CMD_ADDR);
        end
    end

    function automatic logic prog_slot(input int idx);
        logic [2:0] slots;
        // Named views already map each line's bits to the slot order
        slots = {issue_blown, lock_b_blown, lock_a_blown};
        return slots[idx];
    endfunction

    // Map programming address to physical fuse bit
    function automatic logic [2:0] slot_mask(input logic [7:0] a);
        logic [2:0] m;
        m = 3'h0;
        if (a == `SFAC_PROG_ADDR_1ST)
            m = PRODUCT_LINE_B ? 3'h4 : 3'h1;
        else if (a == `SFAC_PROG_ADDR_2ND)
            m = 3'h2;
        else
            m = PRODUCT_LINE_B ? 3'h1 : 3'h4;
        return m;
    endfunction

    // Access matrix
    logic grant;
    logic all_locked;
    logic own_set;
    assign all_locked = lock_a_blown && lock_b_blown && issue_blown;
    assign own_set = wpw_ff && (wset_ff == dif.pw_set);

    // configuration area decisions only; reserved bits unused
    always_comb
    begin
        grant = 1'b0;
        if (CMD_READ)
        begin
            case (dif.area)
                SFAC_AREA_KEY, SFAC_AREA_SECRET:
                    grant = PRODUCT_LINE_B ? (tpw_ff && !lock_b_blown && (!lock_a_blown || ENCRYPTION_ACTIVE))
                                           : (tpw_ff && !issue_blown);
                SFAC_AREA_PW:
                    grant = issue_blown ? own_set
                                        : (tpw_ff && (!PRODUCT_LINE_B || !lock_a_blown || lock_b_blown
                                                      || ENCRYPTION_ACTIVE));
                SFAC_AREA_FORBID: grant = 1'b0;
                default:          grant = 1'b1;
            endcase
        end
        else
        begin
            case (dif.area)
                SFAC_AREA_MTZ: grant = 1'b1;
                SFAC_AREA_HWR: grant = !PRODUCT_LINE_B && (tpw_ff && !lock_a_blown);
                SFAC_AREA_ANTI: grant = tpw_ff && (PRODUCT_LINE_B ? !issue_blown : !lock_a_blown);
                SFAC_AREA_CMC:
                    grant = tpw_ff && (PRODUCT_LINE_B ? !issue_blown : !lock_b_blown);
                SFAC_AREA_LOT: grant = 1'b0;
                SFAC_AREA_DCR:
                    grant = tpw_ff && (PRODUCT_LINE_B ? !lock_b_blown : !issue_blown);
                SFAC_AREA_AC:   grant = tpw_ff && !issue_blown;
                SFAC_AREA_CRYPTO:
                    grant = tpw_ff && (PRODUCT_LINE_B ? !lock_b_blown : !issue_blown);
                SFAC_AREA_KEY, SFAC_AREA_SECRET:
                    grant = PRODUCT_LINE_B ? (tpw_ff && !lock_b_blown && (!lock_a_blown || ENCRYPTION_ACTIVE))
                                           : (tpw_ff && !issue_blown);
                SFAC_AREA_PW:
                    grant = issue_blown ? own_set
                                        : (tpw_ff && (!PRODUCT_LINE_B || !lock_a_blown || lock_b_blown
                                                      || ENCRYPTION_ACTIVE));
                SFAC_AREA_PAC:
                    grant = issue_blown ? own_set : tpw_ff;
                default: grant = 1'b0;
            endcase
        end
        // full lock forces the most restrictive column, already encoded by issue_blown
        if (all_locked && !CMD_READ && dif.area != SFAC_AREA_MTZ && dif.area != SFAC_AREA_PW
            && dif.area != SFAC_AREA_PAC)
            grant = 1'b0;
    end

    // Response registers
    logic       rv_ff, nxt_rv;
    logic       rack_ff, nxt_rack;
    logic       rg_ff, nxt_rg;
    logic       rhd_ff, nxt_rhd;
    logic [7:0] rd_ff, nxt_rd;
    logic [7:0] st_ff, nxt_st;
    logic       lk_ff, nxt_lk;

    always_comb
    begin
        nxt_rv   = CMD_READ || CMD_WRITE;
        nxt_rack = 1'b0;
        nxt_rg   = 1'b0;
        nxt_rhd  = 1'b0;
        nxt_rd   = 8'h00;
        nxt_st   = fuse_byte;
        nxt_lk   = all_locked;
        if (is_fuse_read)
        begin
            nxt_rack = 1'b1;
            nxt_rg   = 1'b1;
            nxt_rhd  = 1'b1;
            nxt_rd   = fuse_byte;
        end
        else if (is_fuse_prog)
        begin
            nxt_rack = order_ok;
            nxt_rg   = order_ok;
            nxt_st   = {`SFAC_FUSE_RSVD, ~fuse_ok & ~{1'b0, prog_pulse}};
            // lock shows with the last fuse
            nxt_lk   = ~|nxt_st[2:0];
        end
        else if (CMD_READ || CMD_WRITE)
        begin
            nxt_rack = grant;
            nxt_rg   = grant;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rv_ff   <= 1'b0;
            rack_ff <= 1'b0;
            rg_ff   <= 1'b0;
            rhd_ff  <= 1'b0;
            rd_ff   <= 8'h00;
            st_ff   <= {`SFAC_FUSE_RSVD, `SFAC_FUSE_RESET};
            lk_ff   <= 1'b0;
        end
        else
        begin
            rv_ff   <= nxt_rv;
            rack_ff <= nxt_rack;
            rg_ff   <= nxt_rg;
            rhd_ff  <= nxt_rhd;
            rd_ff   <= nxt_rd;
            st_ff   <= nxt_st;
            lk_ff   <= nxt_lk;
        end
    end

    assign RESP_VALID    = rv_ff;
    assign RESP_ACK      = rack_ff;
    assign RESP_GRANT    = rg_ff;
    assign RESP_HAS_DATA = rhd_ff;
    assign RESP_DATA     = rd_ff;
    assign STATUS_FUSE   = st_ff;
    assign CONFIG_LOCKED = lk_ff;
endmodule

/* File: verification/sfac_top_sva.sv */
// Port checker of the security fuse block.
// Assumes a bind to sfac_top with the same product line parameter.
`timescale 1ns/10ps

module sfac_top_sva #(
    parameter bit PRODUCT_LINE_B = 1'b0
) (
    input wire logic       CLK,
    input wire logic       RESET_N,
    input wire logic       CMD_READ,
    input wire logic       CMD_WRITE,
    input wire logic [7:0] CMD_OPTION,
    input wire logic [7:0] CMD_ADDR,
    input wire logic [7:0] CMD_LEN,
    input wire logic [7:0] CMD_DATA,
    input wire logic       RESP_VALID,
    input wire logic       RESP_ACK,
    input wire logic       RESP_HAS_DATA,
    input wire logic [7:0] RESP_DATA,
    input wire logic [7:0] STATUS_FUSE,
    input wire logic       CONFIG_LOCKED
);
    localparam int FIRST = PRODUCT_LINE_B ? 2 : 0;
    logic any_cmd;
    logic prog;
    logic plain;
    assign any_cmd = CMD_READ | CMD_WRITE;
    assign prog = CMD_WRITE && CMD_OPTION == 8'h01 && CMD_LEN == 8'h00 && CMD_DATA == 8'h00;
    assign plain = CMD_OPTION != 8'h01;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    a_resp_one_later: assert property (any_cmd |=> RESP_VALID)
        else $error("no response one cycle after a command");
    a_resp_not_idle: assert property (!any_cmd |=> !RESP_VALID)
        else $error("response without a command");
    a_fuse_read_data: assert property (CMD_READ && CMD_OPTION == 8'h01 && CMD_ADDR == 8'hff && CMD_LEN == 8'h00
        |=> RESP_ACK && RESP_HAS_DATA && RESP_DATA == $past(STATUS_FUSE))
        else $error("fuse read did not return the fuse byte");
    a_fuse_never_heals: assert property ((STATUS_FUSE[3:0] & ~$past(STATUS_FUSE[3:0])) == 4'h0)
        else $error("a programmed fuse returned to one");
    a_upper_bits_zero: assert property (STATUS_FUSE[7:3] == 5'h00)
        else $error("factory fuse or upper bits not zero");
    a_order_refused: assert property (prog && ((CMD_ADDR == 8'h04 && STATUS_FUSE[FIRST])
        || (CMD_ADDR == 8'h00 && STATUS_FUSE[1])) |=> !RESP_ACK && $stable(STATUS_FUSE))
        else $error("out of order fuse program accepted");
    a_first_fuse_prog: assert property (prog && CMD_ADDR == 8'h06 && STATUS_FUSE[FIRST]
        |=> RESP_ACK && STATUS_FUSE == ($past(STATUS_FUSE) & ~(8'h01 << FIRST)))
        else $error("first fuse program wrong");
    a_lock_follows_fuses: assert property (CONFIG_LOCKED == (STATUS_FUSE[2:0] == 3'h0))
        else $error("lock level does not match fuses");
    a_lot_write_refused: assert property (CMD_WRITE && plain && CMD_ADDR inside {[8'h10:8'h17]} |=> !RESP_ACK)
        else $error("lot history write accepted");
    a_forbid_refused: assert property (any_cmd && plain && CMD_ADDR inside {[8'hf0:8'hfe]} |=> !RESP_ACK)
        else $error("forbidden area access accepted");
    a_low_reads_open: assert property (CMD_READ && plain && CMD_ADDR <= 8'h4f |=> RESP_ACK)
        else $error("open read refused");
    a_test_area_open: assert property (CMD_WRITE && plain && CMD_ADDR inside {[8'h0a:8'h0b]} |=> RESP_ACK)
        else $error("test area write refused");
endmodule

/* File: verification/sfac_reader_model.sv */
// Reader model: sends one configuration command and takes the answer.
// Assumes the answer comes one cycle after the strobe.
`timescale 1ns/10ps

module sfac_reader_model (
    input  wire logic       clk,
    output logic            cmd_read,
    output logic            cmd_write,
    output logic [7:0]      cmd_option,
    output logic [7:0]      cmd_addr,
    output logic [7:0]      cmd_len,
    output logic [7:0]      cmd_data,
    input  wire logic       resp_valid,
    input  wire logic       resp_ack,
    input  wire logic [7:0] resp_data
);
    initial
    begin
        cmd_read = 1'b0;
        cmd_write = 1'b0;
        cmd_option = 8'h00;
        cmd_addr = 8'h00;
        cmd_len = 8'h00;
        cmd_data = 8'h00;
    end

    task automatic send(input logic wr, input logic [7:0] opt, input logic [7:0] adr,
                        output logic vld, output logic ack, output logic [7:0] dat);
        @(posedge clk);
        #1;
        cmd_write = wr;
        cmd_read = !wr;
        cmd_option = opt;
        cmd_addr = adr;
        cmd_len = 8'h00;
        cmd_data = 8'h00;
        @(posedge clk);
        #1;
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        // Fields lose their value between commands
        cmd_option = ~cmd_option;
        cmd_addr = ~cmd_addr;
        cmd_len = ~cmd_len;
        cmd_data = ~cmd_data;
        vld = resp_valid;
        ack = resp_ack;
        dat = resp_data;
    endtask
endmodule

/* File: verification/sfac_top_tb.sv */
// Testbench of the security fuse block, both product lines side by side.
// Assumes the reader model and the port checker are compiled first.
`timescale 1ns/10ps

module sfac_top_tb;
    logic       clk, reset_n, tpw_ok, wpw_ok, session_end, enc_active;
    logic [2:0] wpw_set;
    logic       cmd_read, cmd_write, resp_valid, resp_ack, resp_has_data, config_locked;
    logic [7:0] cmd_option, cmd_addr, cmd_len, cmd_data, resp_data, status_fuse;
    logic       resp_grant, resp_ack_b, config_locked_b;
    logic [7:0] status_fuse_b;
    int         err_count;
    int         check_count;

    sfac_top i_sfac_top (
        .CLK(clk), .RESET_N(reset_n), .CMD_READ(cmd_read), .CMD_WRITE(cmd_write),
        .CMD_OPTION(cmd_option), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_DATA(cmd_data),
        .TRANSPORT_PASSWORD_OK(tpw_ok), .SET_SET_WRITE_PASSWORD_OK(wpw_ok), .SET_SET_WRITE_PASSWORD_SET(wpw_set),
        .SESSION_END(session_end), .ENCRYPTION_ACTIVE(enc_active), .RESP_VALID(resp_valid),
        .RESP_ACK(resp_ack), .RESP_GRANT(resp_grant), .RESP_HAS_DATA(resp_has_data), .RESP_DATA(resp_data),
        .STATUS_FUSE(status_fuse), .CONFIG_LOCKED(config_locked)
    );

    sfac_top #(.PRODUCT_LINE_B(1'b1)) i_sfac_top_b (
        .CLK(clk), .RESET_N(reset_n), .CMD_READ(cmd_read), .CMD_WRITE(cmd_write),
        .CMD_OPTION(cmd_option), .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_DATA(cmd_data),
        .TRANSPORT_PASSWORD_OK(tpw_ok), .SET_SET_WRITE_PASSWORD_OK(wpw_ok), .SET_SET_WRITE_PASSWORD_SET(wpw_set),
        .SESSION_END(session_end), .ENCRYPTION_ACTIVE(enc_active), .RESP_VALID(),
        .RESP_ACK(resp_ack_b), .RESP_GRANT(), .RESP_HAS_DATA(), .RESP_DATA(),
        .STATUS_FUSE(status_fuse_b), .CONFIG_LOCKED(config_locked_b)
    );

    sfac_reader_model i_sfac_reader_model (
        .clk(clk), .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_option(cmd_option),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_data(cmd_data),
        .resp_valid(resp_valid), .resp_ack(resp_ack), .resp_data(resp_data)
    );

    always #50 clk = ~clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic wr, input logic [7:0] opt, input logic [7:0] adr, input logic ack);
        logic       vld;
        logic       got;
        logic [7:0] dat;
        i_sfac_reader_model.send(wr, opt, adr, vld, got, dat);
        chk1("response valid", 1'b1, vld);
        chk1("acknowledge", ack, got);
        chk1("grant", ack, resp_grant);
        chk1("data flag", 1'b0, resp_has_data);
        chk8("response data", 8'h00, dat);
    endtask

    task automatic acc_ab(input logic [7:0] adr, input logic ack_a, input logic ack_b);
        logic       vld;
        logic       got;
        logic [7:0] dat;
        i_sfac_reader_model.send(1'b0, 8'h00, adr, vld, got, dat);
        chk1("acknowledge", ack_a, got);
        chk1("second line acknowledge", ack_b, resp_ack_b);
    endtask

    task automatic pulse(input logic tp, input logic wp, input logic [2:0] set, input logic se);
        @(posedge clk);
        #1;
        tpw_ok = tp;
        wpw_ok = wp;
        wpw_set = set;
        session_end = se;
        @(posedge clk);
        #1;
        tpw_ok = 1'b0;
        wpw_ok = 1'b0;
        session_end = 1'b0;
    endtask

    task automatic t_defaults;
        logic       vld;
        logic       got;
        logic [7:0] dat;
        chk8("fuse status", 8'h07, status_fuse);
        chk8("second line fuse status", 8'h07, status_fuse_b);
        chk1("config lock", 1'b0, config_locked);
        i_sfac_reader_model.send(1'b0, 8'h01, 8'hff, vld, got, dat);
        chk1("fuse read ack", 1'b1, got);
        chk1("fuse read data flag", 1'b1, resp_has_data);
        chk8("fuse byte", 8'h07, dat);
        $display("defaults test done");
    endtask

    task automatic t_open;
        acc(1'b1, 8'h00, 8'h0a, 1'b1);
        acc(1'b1, 8'h00, 8'h12, 1'b0);
        acc(1'b0, 8'h00, 8'h12, 1'b1);
        acc(1'b0, 8'h00, 8'hf4, 1'b0);
        acc(1'b1, 8'h00, 8'h02, 1'b0);
        acc(1'b1, 8'h00, 8'h0c, 1'b0);
        $display("open access test done");
    endtask

    task automatic t_transport;
        pulse(1'b1, 1'b0, 3'h0, 1'b0);
        acc(1'b1, 8'h00, 8'h02, 1'b1);
        acc(1'b0, 8'h00, 8'h5c, 1'b1);
        acc(1'b1, 8'h00, 8'h20, 1'b1);
        pulse(1'b0, 1'b0, 3'h0, 1'b1);
        acc(1'b1, 8'h00, 8'h02, 1'b0);
        $display("transport password test done");
    endtask

    task automatic t_order;
        pulse(1'b1, 1'b0, 3'h0, 1'b0);
        acc(1'b1, 8'h01, 8'h04, 1'b0);
        acc(1'b1, 8'h01, 8'h00, 1'b0);
        chk8("fuse status", 8'h07, status_fuse);
        chk8("second line fuse status", 8'h07, status_fuse_b);
        acc(1'b1, 8'h01, 8'h06, 1'b1);
        chk8("fuse status", 8'h06, status_fuse);
        chk8("second line fuse status", 8'h03, status_fuse_b);
        acc_ab(8'h5c, 1'b1, 1'b0);
        enc_active = 1'b1;
        acc_ab(8'h5c, 1'b1, 1'b1);
        enc_active = 1'b0;
        acc(1'b1, 8'h00, 8'h02, 1'b0);
        acc(1'b1, 8'h00, 8'h0c, 1'b1);
        acc(1'b1, 8'h01, 8'h04, 1'b1);
        chk8("fuse status", 8'h04, status_fuse);
        chk8("second line fuse status", 8'h01, status_fuse_b);
        acc(1'b1, 8'h00, 8'h0c, 1'b0);
        acc(1'b1, 8'h00, 8'h5c, 1'b1);
        acc(1'b1, 8'h01, 8'h00, 1'b1);
        chk8("fuse status", 8'h00, status_fuse);
        chk8("second line fuse status", 8'h00, status_fuse_b);
        chk1("config lock", 1'b1, config_locked);
        chk1("second line config lock", 1'b1, config_locked_b);
        acc(1'b1, 8'h01, 8'h06, 1'b0);
        chk8("fuse status", 8'h00, status_fuse);
        chk8("second line fuse status", 8'h00, status_fuse_b);
        acc(1'b0, 8'h00, 8'h5c, 1'b0);
        acc_ab(8'h5c, 1'b0, 1'b0);
        acc(1'b1, 8'h00, 8'h20, 1'b0);
        acc(1'b0, 8'h00, 8'h0c, 1'b1);
        $display("fuse order test done");
    endtask

    task automatic t_set_write_password;
        acc(1'b1, 8'h00, 8'hb2, 1'b0);
        pulse(1'b0, 1'b1, 3'h0, 1'b0);
        acc(1'b1, 8'h00, 8'hb2, 1'b1);
        acc(1'b1, 8'h00, 8'hb0, 1'b1);
        acc(1'b1, 8'h00, 8'hba, 1'b0);
        $display("write password test done");
    endtask

    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        tpw_ok = 1'b0;
        wpw_ok = 1'b0;
        wpw_set = 3'h0;
        session_end = 1'b0;
        enc_active = 1'b0;
        err_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_defaults();
        t_open();
        t_transport();
        t_order();
        t_set_write_password();
        report_and_stop();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("run cut short");
        report_and_stop();
    end
endmodule

bind sfac_top sfac_top_sva #(.PRODUCT_LINE_B(PRODUCT_LINE_B)) i_sfac_top_sva (
    .CLK(CLK), .RESET_N(RESET_N), .CMD_READ(CMD_READ), .CMD_WRITE(CMD_WRITE),
    .CMD_OPTION(CMD_OPTION), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN), .CMD_DATA(CMD_DATA), .RESP_VALID(RESP_VALID),
    .RESP_ACK(RESP_ACK), .RESP_HAS_DATA(RESP_HAS_DATA), .RESP_DATA(RESP_DATA),
    .STATUS_FUSE(STATUS_FUSE), .CONFIG_LOCKED(CONFIG_LOCKED)
);
